// File: rtl/ptl_defines.svh
// constants for the pci target lock, parity and interrupt block
// assumes a 32-bit pci bus sampled on the rising edge of clk
`ifndef PTL_DEFINES_SVH
`define PTL_DEFINES_SVH
`define PTL_CMD_SERR_EN_BIT   8
`define PTL_CMD_PERR_EN_BIT   6
`define PTL_STS_SIG_SERR_BIT  14
`define PTL_STS_DET_PERR_BIT  15
`define PTL_CMD_SPECIAL       4'h1
`define PTL_CMD_WRITE_BIT     0
`define PTL_REG_CMD           4'h0
`define PTL_REG_STS           4'h1
`define PTL_REG_INT           4'h2
`define PTL_REG_LOCK          4'h3
`define PTL_REG_TERM          4'h4
`define PTL_REG_ADDR          4'h5
`define PTL_REG_BUSY          4'h6
`define PTL_REG_RESULT        4'h7
`define PTL_REG_START         4'h8
`define PTL_TERM_NORMAL       2'h0
`define PTL_TERM_RETRY        2'h1
`define PTL_TERM_DISCONNECT   2'h2
`define PTL_TERM_ABORT        2'h3
`endif

// File: rtl/ptl_pkg.sv
// types shared by both ends of the pci target lock and parity block
// assumes ptl_defines.svh for all numeric constants
`include "ptl_defines.svh"
package ptl_pkg;
  typedef logic [31:0] ptl_word_type;
  typedef logic [3:0]  ptl_nib_type;
  typedef logic [1:0]  ptl_term_type;
endpackage

// File: rtl/ptl_bus_if.sv
// pci signal bundle joining initiator and target ends
// open-drain and shared lines stay as separate value and enable signals; nothing resolves them
`timescale 1ns/100ps
interface ptl_bus_if;
  import ptl_pkg::*;
  ptl_word_type ad_m;
  logic         ad_m_oe;
  ptl_word_type ad_t;
  logic         ad_t_oe;
  ptl_nib_type  cbe_n;
  logic         par_m;
  logic         par_m_oe;
  logic         par_t;
  logic         par_t_oe;
  logic         frame_n;
  logic         irdy_n;
  logic         lock_n;
  logic         devsel_n;
  logic         trdy_n;
  logic         stop_n;
  logic         t_oe;
  logic         perr_n_out;
  logic         perr_n_oe;
  logic         serr_n_out;
  logic         serr_n_oe;
  logic         inta_n_out;
  logic         inta_n_oe;
  modport target (input ad_m, ad_m_oe, cbe_n, par_m, par_m_oe, frame_n, irdy_n, lock_n,
                  output ad_t, ad_t_oe, par_t, par_t_oe, devsel_n, trdy_n, stop_n, t_oe,
                  perr_n_out, perr_n_oe, serr_n_out, serr_n_oe, inta_n_out, inta_n_oe);
  modport initiator (output ad_m, ad_m_oe, cbe_n, par_m, par_m_oe, frame_n, irdy_n, lock_n,
                     input ad_t, ad_t_oe, par_t, par_t_oe, devsel_n, trdy_n, stop_n, t_oe,
                     perr_n_out, perr_n_oe, serr_n_out, serr_n_oe, inta_n_out, inta_n_oe);
endinterface

// File: rtl/ptl_target.sv
// pci target end: lock tracking, termination encoding, inta, parity checks
// assumes a single pci initiator model on the far side and the simple register port
// How it works
// - lock when selected unlocked, lock asserted next
// - owner drops lock in address clock
// - unlock after final transfer with lock high
// - unlocked target ignores lock asserted at start
// - locked target retries non-owner accesses
// - master takes lock after first frame
// - retry pin encoding only; no disconnect or abort
// - never answer with target abort
// - inta open drain, held until software clears
// - inta held while add-on input low
// - add-on releases input before inta clears
// - even parity over ad, cbe, par
// - address parity error gives serr if enabled
// - serr low exactly one clock per error
// - status bit 14 on address parity error
// - perr driven only as selected write target
// - status bit 15 on every data error
// - perr two clocks after transfer, one clock
// - check data only when irdy and trdy low
// - no perr for special cycles
`timescale 1ns/100ps
`include "ptl_defines.svh"
module ptl_target (
  input  wire logic          clk,
  input  wire logic          srst,
  ptl_bus_if.target          bus,
  input  wire logic          addon_interrupt_in_n,
  input  wire logic          int_source_set,
  input  wire ptl_pkg::ptl_nib_type reg_addr,
  input  wire ptl_pkg::ptl_word_type reg_wdata,
  input  wire logic          reg_write,
  input  wire logic          reg_read,
  output      ptl_pkg::ptl_word_type reg_rdata,
  output      logic          locked
);
  import ptl_pkg::*;

  typedef enum logic [1:0] {PTL_IDLE, PTL_ADDR, PTL_DATA, PTL_TURN} ptl_tstate_type;
  ptl_tstate_type state_reg;
  ptl_tstate_type state_next;

  logic [15:0]   command_register;
  logic [15:0]   status_register;
  logic          int_pending_reg;
  ptl_word_type  reg_rdata_reg;
  logic          locked_reg;
  logic          lock_n_first_reg;
  logic          retry_reg;
  logic          write_reg;
  logic          special_reg;
  logic          addr_chk_reg;
  ptl_word_type  ad_prev_reg;
  ptl_nib_type   cbe_prev_reg;
  logic          data_chk_reg;
  logic          serr_n_reg;
  logic          perr_n_reg;
  logic          perr_oe_reg;
  logic          inta_oe_reg;
  logic          devsel_n_reg;
  logic          trdy_n_reg;
  logic          stop_n_reg;
  logic          t_oe_reg;
  logic          lock_seen_reg;

  // the initiator model drives ad from the address clock through the data phase, reads included
  wire frame_start  = (state_reg == PTL_IDLE) && !bus.frame_n;
  wire is_write     = bus.cbe_n[`PTL_CMD_WRITE_BIT];
  wire is_special   = (bus.cbe_n == `PTL_CMD_SPECIAL);
  wire xfer         = !bus.irdy_n && !trdy_n_reg && !devsel_n_reg;
  wire last_xfer    = xfer && bus.frame_n;
  wire ended        = !bus.irdy_n && !stop_n_reg && bus.frame_n;
  wire par_calc     = ^{ad_prev_reg, cbe_prev_reg};
  wire par_bad      = par_calc != bus.par_m;
  wire addr_err     = addr_chk_reg && par_bad;
  wire data_err     = data_chk_reg && par_bad;
  // owner starts with lock high; a stranger sees lock asserted at frame start
  wire foreign      = locked_reg && !bus.lock_n;
  wire sts_w1c_14   = reg_write && reg_addr == `PTL_REG_STS && reg_wdata[`PTL_STS_SIG_SERR_BIT];
  wire sts_w1c_15   = reg_write && reg_addr == `PTL_REG_STS && reg_wdata[`PTL_STS_DET_PERR_BIT];
  wire int_clear    = reg_write && reg_addr == `PTL_REG_INT && reg_wdata[0];
  wire inta_active  = int_pending_reg || !addon_interrupt_in_n;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PTL_IDLE: if (!bus.frame_n) state_next = PTL_ADDR;
      PTL_ADDR: state_next = PTL_DATA;
      PTL_DATA: if (last_xfer || ended) state_next = PTL_TURN;
      PTL_TURN: state_next = PTL_IDLE;
      default:  state_next = PTL_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) state_reg <= PTL_IDLE;
    else      state_reg <= state_next;
  end

  // transaction capture
  always_ff @(posedge clk) begin
    if (srst) begin
      lock_n_first_reg <= 1'b1;
      retry_reg        <= 1'b0;
      write_reg        <= 1'b0;
      special_reg      <= 1'b0;
      lock_seen_reg    <= 1'b0;
    end else if (frame_start) begin
      lock_n_first_reg <= bus.lock_n;
      retry_reg        <= foreign;
      write_reg        <= is_write;
      special_reg      <= is_special;
      lock_seen_reg    <= 1'b0;
    end else if (state_reg == PTL_DATA && last_xfer) begin
      lock_seen_reg    <= bus.lock_n;
    end
  end

  // lock state
  always_ff @(posedge clk) begin
    if (srst) begin
      locked_reg <= 1'b0;
    end else if (state_reg == PTL_ADDR && lock_n_first_reg && !bus.lock_n && !retry_reg) begin
      locked_reg <= 1'b1;
    end else if (state_reg == PTL_TURN && locked_reg && lock_seen_reg && !retry_reg) begin
      locked_reg <= 1'b0;
    end
  end

  // target pin encoding; a retry moves no data and abort is never produced
  always_ff @(posedge clk) begin
    if (srst) begin
      devsel_n_reg <= 1'b1;
      trdy_n_reg   <= 1'b1;
      stop_n_reg   <= 1'b1;
      t_oe_reg     <= 1'b0;
    end else if (state_reg == PTL_ADDR) begin
      devsel_n_reg <= 1'b0;
      trdy_n_reg   <= retry_reg;
      stop_n_reg   <= !retry_reg;
      t_oe_reg     <= 1'b1;
    end else if (state_reg == PTL_DATA && (last_xfer || ended)) begin
      devsel_n_reg <= 1'b1;
      trdy_n_reg   <= 1'b1;
      stop_n_reg   <= 1'b1;
    end else if (state_reg == PTL_TURN || state_reg == PTL_IDLE) begin
      t_oe_reg     <= 1'b0;
    end
  end

  // parity pipeline: par follows its ad and cbe by one clock
  always_ff @(posedge clk) begin
    if (srst) begin
      addr_chk_reg <= 1'b0;
      data_chk_reg <= 1'b0;
      ad_prev_reg  <= '0;
      cbe_prev_reg <= '0;
    end else begin
      ad_prev_reg  <= bus.ad_m;
      cbe_prev_reg <= bus.cbe_n;
      addr_chk_reg <= frame_start;
      data_chk_reg <= state_reg == PTL_DATA && xfer && write_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      serr_n_reg  <= 1'b1;
      perr_n_reg  <= 1'b1;
      perr_oe_reg <= 1'b0;
    end else begin
      serr_n_reg  <= !(addr_err && command_register[`PTL_CMD_SERR_EN_BIT]);
      // par trails its transfer by a clock, so this register lands two clocks after it
      perr_n_reg  <= !(data_err && !special_reg
                       && command_register[`PTL_CMD_PERR_EN_BIT]);
      perr_oe_reg <= write_reg && (state_reg != PTL_IDLE || data_err);
    end
  end

  // status bits: the hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (srst) begin
      status_register  <= '0;
      command_register <= '0;
      int_pending_reg  <= 1'b0;
      inta_oe_reg      <= 1'b0;
    end else begin
      if (addr_err) status_register[`PTL_STS_SIG_SERR_BIT] <= 1'b1;
      else if (sts_w1c_14) status_register[`PTL_STS_SIG_SERR_BIT] <= 1'b0;
      if (data_err) status_register[`PTL_STS_DET_PERR_BIT] <= 1'b1;
      else if (sts_w1c_15) status_register[`PTL_STS_DET_PERR_BIT] <= 1'b0;
      if (reg_write && reg_addr == `PTL_REG_CMD) command_register <= reg_wdata[15:0];
      if (int_source_set) int_pending_reg <= 1'b1;
      else if (int_clear) int_pending_reg <= 1'b0;
      inta_oe_reg <= inta_active;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) reg_rdata_reg <= '0;
    else if (reg_read) begin
      case (reg_addr)
        `PTL_REG_CMD:  reg_rdata_reg <= {16'h0000, command_register};
        `PTL_REG_STS:  reg_rdata_reg <= {16'h0000, status_register};
        `PTL_REG_INT:  reg_rdata_reg <= {30'h00000000, !addon_interrupt_in_n, int_pending_reg};
        `PTL_REG_LOCK: reg_rdata_reg <= {31'h00000000, locked_reg};
        default:       reg_rdata_reg <= '0;
      endcase
    end else reg_rdata_reg <= '0;
  end

  assign bus.ad_t       = '0;
  assign bus.ad_t_oe    = 1'b0;
  assign bus.par_t      = 1'b0;
  assign bus.par_t_oe   = 1'b0;
  assign bus.devsel_n   = devsel_n_reg;
  assign bus.trdy_n     = trdy_n_reg;
  assign bus.stop_n     = stop_n_reg;
  assign bus.t_oe       = t_oe_reg;
  assign bus.serr_n_out = 1'b0;
  assign bus.serr_n_oe  = !serr_n_reg;
  assign bus.perr_n_out = perr_n_reg;
  assign bus.perr_n_oe  = perr_oe_reg;
  assign bus.inta_n_out = 1'b0;
  assign bus.inta_n_oe  = inta_oe_reg;
  assign reg_rdata      = reg_rdata_reg;
  assign locked         = locked_reg;
endmodule

// File: rtl/ptl_initiator.sv
// pci initiator end: runs one single-data-phase access per start order
// assumes the target end on the other modport and the simple register port
`timescale 1ns/100ps
`include "ptl_defines.svh"
module ptl_initiator (
  input  wire logic          clk,
  input  wire logic          srst,
  ptl_bus_if.initiator       bus,
  input  wire ptl_pkg::ptl_nib_type reg_addr,
  input  wire ptl_pkg::ptl_word_type reg_wdata,
  input  wire logic          reg_write,
  input  wire logic          reg_read,
  output      ptl_pkg::ptl_word_type reg_rdata
);
  import ptl_pkg::*;

  typedef enum logic [2:0] {PTI_IDLE, PTI_ADDR, PTI_WAIT, PTI_LAST, PTI_DONE} ptl_istate_type;
  ptl_istate_type state_reg;
  ptl_istate_type state_next;

  ptl_word_type addr_reg;
  ptl_word_type data_reg;
  ptl_nib_type  cmd_reg;
  logic         use_lock_reg;
  logic         owner_reg;
  logic         keep_lock_reg;
  logic         bad_par_reg;
  ptl_term_type result_reg;
  ptl_word_type reg_rdata_reg;
  ptl_word_type ad_reg;
  ptl_nib_type  cbe_reg;
  logic         frame_n_reg;
  logic         irdy_n_reg;
  logic         lock_n_reg;
  logic         par_reg;
  logic         par_oe_reg;
  logic         ad_oe_reg;
  logic         par_due_reg;
  logic         serr_seen_reg;

  wire start     = reg_write && reg_addr == `PTL_REG_START && state_reg == PTI_IDLE;
  wire hit_done  = !bus.devsel_n && (!bus.trdy_n || !bus.stop_n);
  wire term_kind = !bus.trdy_n;
  ptl_term_type term_code;
  assign term_code = term_kind ? (bus.stop_n ? `PTL_TERM_NORMAL : `PTL_TERM_DISCONNECT)
                               : `PTL_TERM_RETRY;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PTI_IDLE: if (start) state_next = PTI_ADDR;
      PTI_ADDR: state_next = PTI_WAIT;
      PTI_WAIT: if (hit_done) state_next = PTI_LAST;
      PTI_LAST: state_next = PTI_DONE;
      PTI_DONE: state_next = PTI_IDLE;
      default:  state_next = PTI_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) state_reg <= PTI_IDLE;
    else      state_reg <= state_next;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      addr_reg <= '0;
      data_reg <= '0;
      cmd_reg  <= '0;
      use_lock_reg  <= 1'b0;
      keep_lock_reg <= 1'b0;
      bad_par_reg   <= 1'b0;
    end else if (reg_write && state_reg == PTI_IDLE) begin
      if (reg_addr == `PTL_REG_ADDR) addr_reg <= reg_wdata;
      if (reg_addr == `PTL_REG_START) begin
        data_reg      <= reg_wdata;
        cmd_reg       <= addr_reg[3:0];
        use_lock_reg  <= addr_reg[4];
        keep_lock_reg <= addr_reg[5];
        bad_par_reg   <= addr_reg[6];
      end
    end
  end

  // owner drops lock in the address clock, a new locker drives it the next clock
  always_ff @(posedge clk) begin
    if (srst) begin
      frame_n_reg <= 1'b1;
      irdy_n_reg  <= 1'b1;
      lock_n_reg  <= 1'b1;
      ad_oe_reg   <= 1'b0;
      ad_reg      <= '0;
      cbe_reg     <= '0;
      owner_reg   <= 1'b0;
      result_reg  <= `PTL_TERM_NORMAL;
    end else begin
      case (state_reg)
        PTI_IDLE: if (start) begin
          frame_n_reg <= 1'b0;
          ad_oe_reg   <= 1'b1;
          ad_reg      <= {addr_reg[31:2], 2'b00};
          cbe_reg     <= addr_reg[3:0];
          // address bit 7 keeps lock asserted at frame start, posing as another master
          lock_n_reg  <= (owner_reg && !addr_reg[7]) ? 1'b1 : lock_n_reg;
        end
        PTI_ADDR: begin
          frame_n_reg <= 1'b1;
          irdy_n_reg  <= 1'b0;
          ad_reg      <= data_reg;
          cbe_reg     <= 4'h0;
          if (use_lock_reg) lock_n_reg <= 1'b0;
        end
        PTI_WAIT: if (hit_done) begin
          irdy_n_reg <= 1'b1;
          ad_oe_reg  <= 1'b0;
          result_reg <= term_code;
          if (term_kind && use_lock_reg) owner_reg <= 1'b1;
          if (term_kind && !keep_lock_reg) begin
            lock_n_reg <= 1'b1;
            owner_reg  <= 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // parity one clock behind the phase it covers; a flip can inject an error
  always_ff @(posedge clk) begin
    if (srst) begin
      par_reg     <= 1'b0;
      par_oe_reg  <= 1'b0;
      par_due_reg <= 1'b0;
    end else begin
      par_due_reg <= ad_oe_reg;
      par_oe_reg  <= ad_oe_reg;
      par_reg     <= (^{ad_reg, cbe_reg}) ^ bad_par_reg;
    end
  end

  // serr lasts one clock, so it is caught here and held until the next start
  always_ff @(posedge clk) begin
    if (srst || start) serr_seen_reg <= 1'b0;
    else if (bus.serr_n_oe) serr_seen_reg <= 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst) reg_rdata_reg <= '0;
    else if (reg_read) begin
      case (reg_addr)
        `PTL_REG_BUSY:   reg_rdata_reg <= {31'h00000000, state_reg != PTI_IDLE};
        `PTL_REG_RESULT: reg_rdata_reg <= {27'h0000000, bus.inta_n_oe, serr_seen_reg,
                                           owner_reg, result_reg};
        `PTL_REG_ADDR:   reg_rdata_reg <= addr_reg;
        default:         reg_rdata_reg <= '0;
      endcase
    end else reg_rdata_reg <= '0;
  end

  assign bus.ad_m     = ad_reg;
  assign bus.ad_m_oe  = ad_oe_reg;
  assign bus.cbe_n    = cbe_reg;
  assign bus.par_m    = par_reg;
  assign bus.par_m_oe = par_oe_reg && par_due_reg;
  assign bus.frame_n  = frame_n_reg;
  assign bus.irdy_n   = irdy_n_reg;
  assign bus.lock_n   = lock_n_reg;
  assign reg_rdata    = reg_rdata_reg;
endmodule

// File: tb/ptl_assertions.sv
// concurrent checks on the pci signals between initiator and target ends
// assumes the bus interface signals are wired straight in, one clock domain
`timescale 1ns/100ps
module ptl_assertions (
  input wire logic              clk,
  input wire logic              srst,
  input wire ptl_pkg::ptl_word_type ad_m,
  input wire ptl_pkg::ptl_nib_type  cbe_n,
  input wire logic              par_m,
  input wire logic              frame_n,
  input wire logic              irdy_n,
  input wire logic              devsel_n,
  input wire logic              trdy_n,
  input wire logic              stop_n,
  input wire logic              t_oe,
  input wire logic              serr_n_oe,
  input wire logic              perr_n_out,
  input wire logic              perr_n_oe
);
  import ptl_pkg::*;
  logic        frame_d_reg;
  logic        word_par_reg;
  logic        addr_clk_reg;
  ptl_nib_type cmd_reg;
  wire         addr_clk = !frame_n && frame_d_reg && irdy_n;
  // address parity judged with par from the clock after the address
  wire         addr_err = addr_clk_reg && (word_par_reg ^ par_m);
  wire         perr_low = perr_n_oe && !perr_n_out;
  always_ff @(posedge clk) begin
    frame_d_reg  <= srst ? 1'b1 : frame_n;
    word_par_reg <= ^{ad_m, cbe_n};
    addr_clk_reg <= !srst && addr_clk;
    if (addr_clk) begin
      cmd_reg <= cbe_n;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  no_target_abort_a: assert property (!stop_n |-> !devsel_n)
    else $error("stop driven without devsel");
  devsel_driven_a: assert property (!devsel_n |-> t_oe)
    else $error("devsel low while target outputs not enabled");
  respond_timing_a: assert property ($fell(devsel_n) |-> $past(!frame_n, 2) && $past(frame_n, 3))
    else $error("devsel not two clocks after address");
  release_end_a: assert property (
    (!devsel_n && !irdy_n && (!trdy_n || !stop_n)) |=> devsel_n && trdy_n && stop_n)
    else $error("target lines held after termination");
  serr_cause_a: assert property ($rose(serr_n_oe) |-> $past(addr_err))
    else $error("serr without address parity error");
  serr_pulse_a: assert property (serr_n_oe |=> !serr_n_oe)
    else $error("serr longer than one clock");
  perr_timing_a: assert property (perr_low |-> $past(!irdy_n && !trdy_n, 2))
    else $error("perr not two clocks after transfer");
  perr_pulse_a: assert property (perr_low |=> !perr_low)
    else $error("perr longer than one clock");
  perr_write_only_a: assert property (perr_low |-> cmd_reg[0] && cmd_reg != 4'h1)
    else $error("perr on read or special cycle");
  reset_release_a: assert property ($fell(srst) |-> !serr_n_oe && !perr_n_oe && devsel_n)
    else $error("error lines not released by reset");
endmodule

// File: tb/testbench.sv
// self-checking bench: initiator and target ends joined by the bus interface
// assumes both ends answer register reads one cycle after the read strobe
`timescale 1ns/100ps
module testbench;
  import ptl_pkg::*;
  typedef struct {ptl_word_type cfg; ptl_term_type term; logic lck;} ptl_case_type;
  logic         clk = 1'b0;
  logic         srst = 1'b1;
  logic         addon_n = 1'b1;
  logic         int_set = 1'b0;
  ptl_nib_type  t_addr = 4'h0;
  ptl_word_type t_wdata = 32'h0;
  logic         t_wr = 1'b0;
  logic         t_rd = 1'b0;
  ptl_word_type t_rdata;
  logic         locked;
  ptl_nib_type  i_addr = 4'h0;
  ptl_word_type i_wdata = 32'h0;
  logic         i_wr = 1'b0;
  logic         i_rd = 1'b0;
  ptl_word_type i_rdata;
  ptl_word_type q;
  ptl_word_type res;
  int           checks = 0;
  int           miscompares = 0;
  ptl_case_type rows [5];
  always #5 clk = ~clk;
  ptl_bus_if ptl_bus_if_inst ();
  ptl_target ptl_target_inst (.clk(clk), .srst(srst), .bus(ptl_bus_if_inst.target),
    .addon_interrupt_in_n(addon_n), .int_source_set(int_set), .reg_addr(t_addr),
    .reg_wdata(t_wdata), .reg_write(t_wr), .reg_read(t_rd), .reg_rdata(t_rdata),
    .locked(locked));
  ptl_initiator ptl_initiator_inst (.clk(clk), .srst(srst), .bus(ptl_bus_if_inst.initiator),
    .reg_addr(i_addr), .reg_wdata(i_wdata), .reg_write(i_wr), .reg_read(i_rd),
    .reg_rdata(i_rdata));
  ptl_assertions ptl_assertions_inst (.clk(clk), .srst(srst), .ad_m(ptl_bus_if_inst.ad_m),
    .cbe_n(ptl_bus_if_inst.cbe_n), .par_m(ptl_bus_if_inst.par_m),
    .frame_n(ptl_bus_if_inst.frame_n), .irdy_n(ptl_bus_if_inst.irdy_n),
    .devsel_n(ptl_bus_if_inst.devsel_n), .trdy_n(ptl_bus_if_inst.trdy_n),
    .stop_n(ptl_bus_if_inst.stop_n), .t_oe(ptl_bus_if_inst.t_oe),
    .serr_n_oe(ptl_bus_if_inst.serr_n_oe), .perr_n_out(ptl_bus_if_inst.perr_n_out),
    .perr_n_oe(ptl_bus_if_inst.perr_n_oe));
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input ptl_word_type got, input ptl_word_type exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one strobe per call; the strobe drops at the taking edge, so calls never collide
  task automatic reg_op(input logic tgt, input logic wr, input ptl_nib_type a,
                        input ptl_word_type d, output ptl_word_type r);
    @(posedge clk);
    if (tgt) begin
      t_addr <= a; t_wdata <= d; t_wr <= wr; t_rd <= !wr;
    end else begin
      i_addr <= a; i_wdata <= d; i_wr <= wr; i_rd <= !wr;
    end
    @(posedge clk);
    t_wr <= 1'b0; t_rd <= 1'b0; i_wr <= 1'b0; i_rd <= 1'b0;
    #1 r = tgt ? t_rdata : i_rdata;
  endtask
  task automatic access(input ptl_word_type cfg, output ptl_word_type r);
    int n;
    reg_op(1'b0, 1'b1, 4'h5, cfg, r);
    reg_op(1'b0, 1'b1, 4'h8, 32'hA5C3_0F96, r);
    n = 0;
    do begin
      reg_op(1'b0, 1'b0, 4'h6, 32'h0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 40);
    if (n >= 40) chk(r, 32'h0);
    reg_op(1'b0, 1'b0, 4'h7, 32'h0, r);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  initial begin
    #300000;
    miscompares++;
    complete_run();
  end
  initial begin
    // cfg low bits: command, take lock, keep lock; upper bits are the address
    rows[0] = '{32'h1234_5607, 2'h0, 1'b0};
    rows[1] = '{32'h1234_5606, 2'h0, 1'b0};
    rows[2] = '{32'h1234_5637, 2'h0, 1'b1};
    rows[3] = '{32'h1234_5637, 2'h0, 1'b1};
    rows[4] = '{32'h1234_5607, 2'h0, 1'b0};
    cycles(3);
    srst <= 1'b0;
    reg_op(1'b1, 1'b0, 4'h1, 32'h0, q);
    chk(q, 32'h0);
    chk({31'h0, locked}, 32'h0);
    reg_op(1'b1, 1'b0, 4'hF, 32'h0, q);
    chk(q, 32'h0);
    reg_op(1'b1, 1'b1, 4'h0, 32'h0000_0140, q);
    reg_op(1'b1, 1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h0000_0140);
    foreach (rows[i]) begin
      access(rows[i].cfg, res);
      chk({30'h0, res[1:0]}, {30'h0, rows[i].term});
      chk({31'h0, locked}, {31'h0, rows[i].lck});
    end
    access(32'h1234_5647, res);
    reg_op(1'b1, 1'b0, 4'h1, 32'h0, q);
    chk(q, 32'h0000_C000);
    chk({31'h0, res[3]}, 32'h1);
    reg_op(1'b1, 1'b1, 4'h1, 32'h0000_C000, q);
    reg_op(1'b1, 1'b0, 4'h1, 32'h0, q);
    chk(q, 32'h0);
    access(32'h1234_5641, res);
    reg_op(1'b1, 1'b1, 4'h0, 32'h0, q);
    access(32'h1234_5647, res);
    chk({31'h0, res[3]}, 32'h0);
    reg_op(1'b1, 1'b0, 4'h1, 32'h0, q);
    chk(q, 32'h0000_C000);
    @(posedge clk);
    int_set <= 1'b1;
    @(posedge clk);
    int_set <= 1'b0;
    cycles(6);
    chk({31'h0, ptl_bus_if_inst.inta_n_oe}, 32'h1);
    reg_op(1'b1, 1'b1, 4'h2, 32'h1, q);
    cycles(2);
    chk({31'h0, ptl_bus_if_inst.inta_n_oe}, 32'h0);
    @(posedge clk);
    addon_n <= 1'b0;
    cycles(3);
    chk({31'h0, ptl_bus_if_inst.inta_n_oe}, 32'h1);
    reg_op(1'b1, 1'b0, 4'h2, 32'h0, q);
    chk({31'h0, q[1]}, 32'h1);
    reg_op(1'b1, 1'b1, 4'h2, 32'h1, q);
    cycles(2);
    chk({31'h0, ptl_bus_if_inst.inta_n_oe}, 32'h1);
    @(posedge clk);
    addon_n <= 1'b1;
    cycles(3);
    chk({31'h0, ptl_bus_if_inst.inta_n_oe}, 32'h0);
    access(32'h1234_5637, res);
    chk({31'h0, locked}, 32'h1);
    // cfg bit 7 keeps lock asserted at frame start, as a stranger master would
    access(32'h1234_56B7, res);
    chk({30'h0, res[1:0]}, 32'h1);
    chk({31'h0, locked}, 32'h1);
    @(posedge clk);
    srst <= 1'b1;
    cycles(2);
    srst <= 1'b0;
    cycles(1);
    chk({31'h0, locked}, 32'h0);
    chk({31'h0, ptl_bus_if_inst.serr_n_oe | ptl_bus_if_inst.perr_n_oe}, 32'h0);
    complete_run();
  end
endmodule
